// ===== pcie_cap_fields_pkg.sv
// register map, field layout and response codes of the capability field bank
package pcie_cap_fields_pkg;
   localparam int unsigned DATA_W       = 32;
   localparam int unsigned STRB_W       = DATA_W / 8;
   localparam int unsigned REG_AW       = 6;

   localparam logic [REG_AW-1:0] OFF_ERR_HDR   = 6'h00;
   localparam logic [REG_AW-1:0] OFF_ERR_CAPS  = 6'h04;
   localparam logic [REG_AW-1:0] OFF_ALT_HDR   = 6'h08;
   localparam logic [REG_AW-1:0] OFF_ALT_CTRL  = 6'h0c;
   localparam logic [REG_AW-1:0] OFF_PB_HDR    = 6'h10;
   localparam logic [REG_AW-1:0] OFF_PB_CAP    = 6'h14;
   localparam logic [REG_AW-1:0] OFF_LAT_HDR   = 6'h18;
   localparam logic [REG_AW-1:0] OFF_LAT_LIM   = 6'h1c;
   localparam logic [REG_AW-1:0] OFF_RID_IN    = 6'h20;
   localparam logic [REG_AW-1:0] OFF_RID_SPLIT = 6'h24;

   localparam int unsigned NEXT_PTR_LSB  = 20;
   localparam int unsigned NEXT_PTR_W    = 12;
   localparam int unsigned VER_LSB       = 16;
   localparam int unsigned VER_W         = 4;
   localparam int unsigned CAP_ID_W      = 16;

   localparam int unsigned ECRC_GEN_CAP_BIT = 5;
   localparam int unsigned ECRC_GEN_EN_BIT  = 6;
   localparam int unsigned ECRC_CHK_CAP_BIT = 7;
   localparam int unsigned ECRC_CHK_EN_BIT  = 8;

   localparam int unsigned NEXT_FUNC_LSB = 8;
   localparam int unsigned NEXT_FUNC_W   = 8;
   localparam int unsigned SYS_ALLOC_BIT = 0;

   localparam int unsigned LAT_W         = 10;
   localparam int unsigned SNOOP_LSB     = 0;
   localparam int unsigned NOSNOOP_LSB   = 16;

   localparam int unsigned RID_W          = 16;
   localparam int unsigned BUS_W          = 8;
   localparam int unsigned DEV_W          = 5;
   localparam int unsigned FUNC_LEGACY_W  = 3;
   localparam int unsigned FUNC_W         = 8;
   localparam int unsigned SPLIT_BUS_LSB  = 0;
   localparam int unsigned SPLIT_DEV_LSB  = 8;
   localparam int unsigned SPLIT_FUNC_LSB = 16;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pcie_cap_fields_pkg

// ===== ext_cap_header_word.sv
// one extended capability header word built from build-time fields
`timescale 1ns/10ps
module ext_cap_header_word
   import pcie_cap_fields_pkg::*;
#(
   parameter logic [NEXT_PTR_W-1:0] NEXT_PTR = 12'h000,
   parameter logic [VER_W-1:0]      VERSION  = 4'h1,
   parameter logic [CAP_ID_W-1:0]   CAP_ID   = 16'h0000
)
(
   output wire logic [DATA_W-1:0] word
);
   // constant word: no storage, so a write can never alter it
   assign word = {NEXT_PTR, VERSION, CAP_ID};
endmodule : ext_cap_header_word

// ===== pcie_ext_capability_fields.sv
// capability field register bank with an AXI4-Lite slave port
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
// Functional notes
// - next pointers give following offset or zero
// - ecrc check capable appears at bit 7
// - ecrc generate capable appears at bit 5
// - routing off: bus 8, device 5, function 3
// - routing on: bus 8, function 8
// - routing header bits 31:20 next pointer
// - routing header bits 19:16 version
// - routing control bits 15:8 next function
// - power header bits 31:20 next pointer
// - power header bits 19:16 version
// - system allocated shown at power bit 0
// - latency header bits 31:20 next pointer
// - latency header bits 19:16 version
// - snoop latency in bits 9:0
// - no-snoop latency in bits 25:16
module pcie_ext_capability_fields
#(
   parameter int unsigned                                ADDR_W = 12,
   parameter logic [pcie_cap_fields_pkg::NEXT_PTR_W-1:0] ERR_NEXT_PTR = 12'h000,
   parameter logic [pcie_cap_fields_pkg::VER_W-1:0]      ERR_VERSION = 4'h1,
   parameter logic [pcie_cap_fields_pkg::CAP_ID_W-1:0]   ERR_CAP_ID = 16'h0000,
   parameter logic                                       ECRC_CHECK_CAPABLE = 1'h0,
   parameter logic                                       ECRC_GENERATE_CAPABLE = 1'h0,
   parameter logic                                       ALT_ROUTING_ENABLE = 1'h0,
   parameter logic [pcie_cap_fields_pkg::NEXT_PTR_W-1:0] ALT_NEXT_PTR = 12'h000,
   parameter logic [pcie_cap_fields_pkg::VER_W-1:0]      ALT_VERSION = 4'h1,
   parameter logic [pcie_cap_fields_pkg::CAP_ID_W-1:0]   ALT_CAP_ID = 16'h0000,
   parameter logic [pcie_cap_fields_pkg::NEXT_FUNC_W-1:0] ALT_NEXT_FUNCTION = 8'h00,
   parameter logic [pcie_cap_fields_pkg::NEXT_PTR_W-1:0] PB_NEXT_PTR = 12'h000,
   parameter logic [pcie_cap_fields_pkg::VER_W-1:0]      PB_VERSION = 4'h1,
   parameter logic [pcie_cap_fields_pkg::CAP_ID_W-1:0]   PB_CAP_ID = 16'h0000,
   parameter logic                                       PB_SYS_ALLOCATED = 1'h0,
   parameter logic [pcie_cap_fields_pkg::NEXT_PTR_W-1:0] LAT_NEXT_PTR = 12'h000,
   parameter logic [pcie_cap_fields_pkg::VER_W-1:0]      LAT_VERSION = 4'h1,
   parameter logic [pcie_cap_fields_pkg::CAP_ID_W-1:0]   LAT_CAP_ID = 16'h0000,
   parameter logic [pcie_cap_fields_pkg::LAT_W-1:0]      MAX_SNOOP_LATENCY = 10'h000,
   parameter logic [pcie_cap_fields_pkg::LAT_W-1:0]      MAX_NOSNOOP_LATENCY = 10'h000
)
(
   input  wire logic                                     aclk,
   input  wire logic                                     aresetn,
   input  wire logic [ADDR_W-1:0]                        awaddr,
   input  wire logic                                     awvalid,
   output wire logic                                     awready,
   input  wire logic [pcie_cap_fields_pkg::DATA_W-1:0]   wdata,
   input  wire logic [pcie_cap_fields_pkg::STRB_W-1:0]   wstrb,
   input  wire logic                                     wvalid,
   output wire logic                                     wready,
   output wire logic [1:0]                               bresp,
   output wire logic                                     bvalid,
   input  wire logic                                     bready,
   input  wire logic [ADDR_W-1:0]                        araddr,
   input  wire logic                                     arvalid,
   output wire logic                                     arready,
   output wire logic [pcie_cap_fields_pkg::DATA_W-1:0]   rdata,
   output wire logic [1:0]                               rresp,
   output wire logic                                     rvalid,
   input  wire logic                                     rready,
   output wire logic                                     ecrc_generate_enable,
   output wire logic                                     ecrc_check_enable,
   output wire logic                                     alt_routing_enable_cfg,
   output wire logic [pcie_cap_fields_pkg::LAT_W-1:0]    max_snoop_latency,
   output wire logic [pcie_cap_fields_pkg::LAT_W-1:0]    max_nosnoop_latency,
   output wire logic [pcie_cap_fields_pkg::BUS_W-1:0]    rid_bus,
   output wire logic [pcie_cap_fields_pkg::DEV_W-1:0]    rid_device,
   output wire logic [pcie_cap_fields_pkg::FUNC_W-1:0]   rid_function
);
   import pcie_cap_fields_pkg::*;

   if (ADDR_W < REG_AW)
   begin : g_bad_addr_w
      $error("ADDR_W too narrow for the register map");
   end

   // byte-lane merge for the writable words
   function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_w,
                                                    input logic [DATA_W-1:0] new_w,
                                                    input logic [STRB_W-1:0] strb);
      logic [DATA_W-1:0] res;
      res = old_w;
      for (int i = 0; i < STRB_W; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return res;
   endfunction : lane_merge

   logic [DATA_W-1:0] err_hdr_word;
   logic [DATA_W-1:0] alt_hdr_word;
   logic [DATA_W-1:0] pb_hdr_word;
   logic [DATA_W-1:0] lat_hdr_word;

   // each header carries its own chain pointer
   ext_cap_header_word #(.NEXT_PTR(ERR_NEXT_PTR), .VERSION(ERR_VERSION), .CAP_ID(ERR_CAP_ID))
      u_err_hdr (.word(err_hdr_word));
   ext_cap_header_word #(.NEXT_PTR(ALT_NEXT_PTR), .VERSION(ALT_VERSION), .CAP_ID(ALT_CAP_ID))
      u_alt_hdr (.word(alt_hdr_word));
   ext_cap_header_word #(.NEXT_PTR(PB_NEXT_PTR), .VERSION(PB_VERSION), .CAP_ID(PB_CAP_ID))
      u_pb_hdr (.word(pb_hdr_word));
   ext_cap_header_word #(.NEXT_PTR(LAT_NEXT_PTR), .VERSION(LAT_VERSION), .CAP_ID(LAT_CAP_ID))
      u_lat_hdr (.word(lat_hdr_word));

   // write channel state
   logic                aw_have_q;
   logic [ADDR_W-1:0]   aw_addr_q;
   logic                w_have_q;
   logic [DATA_W-1:0]   w_data_q;
   logic [STRB_W-1:0]   w_strb_q;
   logic                bvalid_q;
   logic [1:0]          bresp_q;
   // read channel state
   logic                rvalid_q;
   logic [DATA_W-1:0]   rdata_q;
   logic [1:0]          rresp_q;
   logic [REG_AW-1:0]   raddr_q;
   // software state
   logic                gen_en_q;
   logic                chk_en_q;
   logic [LAT_W-1:0]    snoop_q;
   logic [LAT_W-1:0]    nosnoop_q;
   logic [RID_W-1:0]    rid_q;
   logic [BUS_W-1:0]    rid_bus_q;
   logic [DEV_W-1:0]    rid_dev_q;
   logic [FUNC_W-1:0]   rid_func_q;

   wire aw_fire = awvalid && awready;
   wire w_fire  = wvalid && wready;
   wire ar_fire = arvalid && arready;
   // both halves held: the write is done one edge after the later of the two
   wire wr_go   = aw_have_q && w_have_q;

   assign awready = !aw_have_q && !bvalid_q;
   assign wready  = !w_have_q && !bvalid_q;
   assign arready = !rvalid_q;

   // write decode
   wire [REG_AW-1:0] wr_off    = aw_addr_q[REG_AW-1:0];
   wire              wr_in_map = (aw_addr_q >> REG_AW) == '0;
   wire wsel_err_hdr   = wr_in_map && (wr_off == OFF_ERR_HDR);
   wire wsel_err_caps  = wr_in_map && (wr_off == OFF_ERR_CAPS);
   wire wsel_alt_hdr   = wr_in_map && (wr_off == OFF_ALT_HDR);
   wire wsel_alt_ctrl  = wr_in_map && (wr_off == OFF_ALT_CTRL);
   wire wsel_pb_hdr    = wr_in_map && (wr_off == OFF_PB_HDR);
   wire wsel_pb_cap    = wr_in_map && (wr_off == OFF_PB_CAP);
   wire wsel_lat_hdr   = wr_in_map && (wr_off == OFF_LAT_HDR);
   wire wsel_lat_lim   = wr_in_map && (wr_off == OFF_LAT_LIM);
   wire wsel_rid_in    = wr_in_map && (wr_off == OFF_RID_IN);
   wire wsel_rid_split = wr_in_map && (wr_off == OFF_RID_SPLIT);
   wire wr_mapped = wsel_err_hdr || wsel_err_caps || wsel_alt_hdr || wsel_alt_ctrl
                 || wsel_pb_hdr || wsel_pb_cap || wsel_lat_hdr || wsel_lat_lim
                 || wsel_rid_in || wsel_rid_split;

   // current words of the writable registers, for lane merging
   logic [DATA_W-1:0] err_caps_word;
   logic [DATA_W-1:0] lat_lim_word;
   logic [DATA_W-1:0] rid_in_word;
   always_comb
   begin
      err_caps_word = '0;
      err_caps_word[ECRC_GEN_CAP_BIT] = ECRC_GENERATE_CAPABLE;
      err_caps_word[ECRC_GEN_EN_BIT]  = gen_en_q;
      err_caps_word[ECRC_CHK_CAP_BIT] = ECRC_CHECK_CAPABLE;
      err_caps_word[ECRC_CHK_EN_BIT]  = chk_en_q;
      lat_lim_word = '0;
      lat_lim_word[SNOOP_LSB +: LAT_W]   = snoop_q;
      lat_lim_word[NOSNOOP_LSB +: LAT_W] = nosnoop_q;
      rid_in_word = '0;
      rid_in_word[RID_W-1:0] = rid_q;
   end

   wire [DATA_W-1:0] caps_merged = lane_merge(err_caps_word, w_data_q, w_strb_q);
   wire [DATA_W-1:0] lat_merged  = lane_merge(lat_lim_word, w_data_q, w_strb_q);
   wire [DATA_W-1:0] rid_merged  = lane_merge(rid_in_word, w_data_q, w_strb_q);

   // enables stick at zero unless the matching capability is advertised
   wire gen_en_d  = (wr_go && wsel_err_caps)
                  ? (caps_merged[ECRC_GEN_EN_BIT] && ECRC_GENERATE_CAPABLE) : gen_en_q;
   wire chk_en_d  = (wr_go && wsel_err_caps)
                  ? (caps_merged[ECRC_CHK_EN_BIT] && ECRC_CHECK_CAPABLE) : chk_en_q;
   wire [LAT_W-1:0] snoop_d   = (wr_go && wsel_lat_lim)
                              ? lat_merged[SNOOP_LSB +: LAT_W] : snoop_q;
   wire [LAT_W-1:0] nosnoop_d = (wr_go && wsel_lat_lim)
                              ? lat_merged[NOSNOOP_LSB +: LAT_W] : nosnoop_q;
   wire [RID_W-1:0] rid_d     = (wr_go && wsel_rid_in) ? rid_merged[RID_W-1:0] : rid_q;

   // requester id split, selected by the routing mode
   wire [BUS_W-1:0]  split_bus  = rid_q[RID_W-1 -: BUS_W];
   wire [DEV_W-1:0]  split_dev  = ALT_ROUTING_ENABLE
                                ? '0 : rid_q[FUNC_LEGACY_W +: DEV_W];
   wire [FUNC_W-1:0] split_func = ALT_ROUTING_ENABLE
                                ? rid_q[FUNC_W-1:0]
                                : {{(FUNC_W-FUNC_LEGACY_W){1'b0}},
                                   rid_q[FUNC_LEGACY_W-1:0]};

   // read decode
   wire [REG_AW-1:0] rd_off    = araddr[REG_AW-1:0];
   wire              rd_in_map = (araddr >> REG_AW) == '0;
   wire rsel_err_hdr   = rd_in_map && (rd_off == OFF_ERR_HDR);
   wire rsel_err_caps  = rd_in_map && (rd_off == OFF_ERR_CAPS);
   wire rsel_alt_hdr   = rd_in_map && (rd_off == OFF_ALT_HDR);
   wire rsel_alt_ctrl  = rd_in_map && (rd_off == OFF_ALT_CTRL);
   wire rsel_pb_hdr    = rd_in_map && (rd_off == OFF_PB_HDR);
   wire rsel_pb_cap    = rd_in_map && (rd_off == OFF_PB_CAP);
   wire rsel_lat_hdr   = rd_in_map && (rd_off == OFF_LAT_HDR);
   wire rsel_lat_lim   = rd_in_map && (rd_off == OFF_LAT_LIM);
   wire rsel_rid_in    = rd_in_map && (rd_off == OFF_RID_IN);
   wire rsel_rid_split = rd_in_map && (rd_off == OFF_RID_SPLIT);
   wire rd_mapped = rsel_err_hdr || rsel_err_caps || rsel_alt_hdr || rsel_alt_ctrl
                 || rsel_pb_hdr || rsel_pb_cap || rsel_lat_hdr || rsel_lat_lim
                 || rsel_rid_in || rsel_rid_split;

   logic [DATA_W-1:0] alt_ctrl_word;
   logic [DATA_W-1:0] pb_cap_word;
   logic [DATA_W-1:0] split_word;
   always_comb
   begin
      alt_ctrl_word = '0;
      alt_ctrl_word[NEXT_FUNC_LSB +: NEXT_FUNC_W] = ALT_NEXT_FUNCTION;
      pb_cap_word = '0;
      pb_cap_word[SYS_ALLOC_BIT] = PB_SYS_ALLOCATED;
      split_word = '0;
      split_word[SPLIT_BUS_LSB +: BUS_W]  = split_bus;
      split_word[SPLIT_DEV_LSB +: DEV_W]  = split_dev;
      split_word[SPLIT_FUNC_LSB +: FUNC_W] = split_func;
   end

   // unmapped reads return zero with an error response
   wire [DATA_W-1:0] rd_word = rsel_err_hdr   ? err_hdr_word
                             : rsel_err_caps  ? err_caps_word
                             : rsel_alt_hdr   ? alt_hdr_word
                             : rsel_alt_ctrl  ? alt_ctrl_word
                             : rsel_pb_hdr    ? pb_hdr_word
                             : rsel_pb_cap    ? pb_cap_word
                             : rsel_lat_hdr   ? lat_hdr_word
                             : rsel_lat_lim   ? lat_lim_word
                             : rsel_rid_in    ? rid_in_word
                             : rsel_rid_split ? split_word
                             : '0;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         aw_addr_q <= '0;
         w_have_q  <= 1'b0;
         w_data_q  <= '0;
         w_strb_q  <= '0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end
      else
      begin
         if (aw_fire)
         begin
            aw_have_q <= 1'b1;
            aw_addr_q <= awaddr;
         end
         else if (wr_go)
         begin
            aw_have_q <= 1'b0;
         end
         if (w_fire)
         begin
            w_have_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         else if (wr_go)
         begin
            w_have_q <= 1'b0;
         end
         if (wr_go)
         begin
            bvalid_q <= 1'b1;
            // read-only targets answer okay and keep their value
            bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bready)
         begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= RESP_OKAY;
         raddr_q  <= '0;
      end
      else if (ar_fire)
      begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_word;
         rresp_q  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         raddr_q  <= rd_off;
      end
      else if (rready)
      begin
         rvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         gen_en_q   <= 1'b0;
         chk_en_q   <= 1'b0;
         snoop_q    <= MAX_SNOOP_LATENCY;
         nosnoop_q  <= MAX_NOSNOOP_LATENCY;
         rid_q      <= '0;
         rid_bus_q  <= '0;
         rid_dev_q  <= '0;
         rid_func_q <= '0;
      end
      else
      begin
         gen_en_q   <= gen_en_d;
         chk_en_q   <= chk_en_d;
         snoop_q    <= snoop_d;
         nosnoop_q  <= nosnoop_d;
         rid_q      <= rid_d;
         rid_bus_q  <= split_bus;
         rid_dev_q  <= split_dev;
         rid_func_q <= split_func;
      end
   end

   assign bvalid                 = bvalid_q;
   assign bresp                  = bresp_q;
   assign rvalid                 = rvalid_q;
   assign rdata                  = rdata_q;
   assign rresp                  = rresp_q;
   assign ecrc_generate_enable   = gen_en_q;
   assign ecrc_check_enable      = chk_en_q;
   assign alt_routing_enable_cfg = ALT_ROUTING_ENABLE;
   assign max_snoop_latency      = snoop_q;
   assign max_nosnoop_latency    = nosnoop_q;
   assign rid_bus                = rid_bus_q;
   assign rid_device             = rid_dev_q;
   assign rid_function           = rid_func_q;

   // checks on read and write answers, latency and enable outputs and the id split
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   wire rd_ok = rvalid_q && (rresp_q == RESP_OKAY);

   a_err_next_ptr: assert property (
      rd_ok && raddr_q == OFF_ERR_HDR |-> rdata_q[NEXT_PTR_LSB +: NEXT_PTR_W] == ERR_NEXT_PTR)
      else $error("error report next pointer wrong");
   a_ecrc_check_bit: assert property (
      rd_ok && raddr_q == OFF_ERR_CAPS |-> rdata_q[ECRC_CHK_CAP_BIT] == ECRC_CHECK_CAPABLE)
      else $error("ecrc check capable bit wrong");
   a_ecrc_gen_bit: assert property (
      rd_ok && raddr_q == OFF_ERR_CAPS |-> rdata_q[ECRC_GEN_CAP_BIT] == ECRC_GENERATE_CAPABLE)
      else $error("ecrc generate capable bit wrong");
   a_legacy_rid_split: assert property (
      !ALT_ROUTING_ENABLE |=> rid_device == $past(rid_q[FUNC_LEGACY_W +: DEV_W])
                            && rid_function < 8'h08)
      else $error("legacy requester id split wrong");
   a_alt_rid_split: assert property (
      ALT_ROUTING_ENABLE |=> rid_device == '0 && rid_function == $past(rid_q[FUNC_W-1:0])
                           && rid_bus == $past(rid_q[RID_W-1 -: BUS_W]))
      else $error("alternative requester id split wrong");
   a_alt_next_ptr: assert property (
      rd_ok && raddr_q == OFF_ALT_HDR |-> rdata_q[NEXT_PTR_LSB +: NEXT_PTR_W] == ALT_NEXT_PTR)
      else $error("routing next pointer wrong");
   a_alt_version: assert property (
      rd_ok && raddr_q == OFF_ALT_HDR |-> rdata_q[VER_LSB +: VER_W] == ALT_VERSION)
      else $error("routing version wrong");
   a_alt_next_func: assert property (
      rd_ok && raddr_q == OFF_ALT_CTRL |-> rdata_q[NEXT_FUNC_LSB +: NEXT_FUNC_W]
                                           == ALT_NEXT_FUNCTION)
      else $error("routing next function wrong");
   a_pb_next_ptr: assert property (
      rd_ok && raddr_q == OFF_PB_HDR |-> rdata_q[NEXT_PTR_LSB +: NEXT_PTR_W] == PB_NEXT_PTR)
      else $error("power budget next pointer wrong");
   a_pb_version: assert property (
      rd_ok && raddr_q == OFF_PB_HDR |-> rdata_q[VER_LSB +: VER_W] == PB_VERSION)
      else $error("power budget version wrong");
   a_pb_sys_alloc: assert property (
      rd_ok && raddr_q == OFF_PB_CAP |-> rdata_q[SYS_ALLOC_BIT] == PB_SYS_ALLOCATED)
      else $error("system allocated bit wrong");
   a_lat_next_ptr: assert property (
      rd_ok && raddr_q == OFF_LAT_HDR |-> rdata_q[NEXT_PTR_LSB +: NEXT_PTR_W] == LAT_NEXT_PTR)
      else $error("latency next pointer wrong");
   a_lat_version: assert property (
      rd_ok && raddr_q == OFF_LAT_HDR |-> rdata_q[VER_LSB +: VER_W] == LAT_VERSION)
      else $error("latency version wrong");
   a_snoop_field: assert property (
      wr_go && wsel_lat_lim && w_strb_q[0] |=> max_snoop_latency[7:0] == $past(w_data_q[7:0]))
      else $error("snoop latency write lost");
   a_nosnoop_field: assert property (
      ar_fire && rsel_lat_lim ##1 rvalid_q |-> rdata_q[NOSNOOP_LSB +: LAT_W] == $past(nosnoop_q))
      else $error("no-snoop latency read wrong");
   a_ro_enable_held: assert property (
      !ECRC_GENERATE_CAPABLE |-> !ecrc_generate_enable
                                 && !(rd_ok && raddr_q == OFF_ERR_CAPS
                                      && rdata_q[ECRC_GEN_EN_BIT]))
      else $error("read-only field changed");
   a_write_answer: assert property (
      wr_go |=> bvalid_q [*1] ##0 (bresp_q == ($past(wr_mapped) ? RESP_OKAY : RESP_SLVERR)))
      else $error("write answer missing or wrong");

   c_lat_write:   cover property (wr_go && wsel_lat_lim ##1 bvalid_q && bready);
   c_unmapped_rd: cover property (ar_fire && !rd_mapped ##1 rvalid_q);
   c_rid_read:    cover property (wr_go && wsel_rid_in ##[1:4] ar_fire && rsel_rid_split);
   c_rd_wr_share: cover property (ar_fire && wr_go);
endmodule : pcie_ext_capability_fields

// ===== pcie_ext_capability_fields_bench.sv
// self-checking bench for the capability field bank
`timescale 1ns/10ps
module pcie_ext_capability_fields_bench;
   import pcie_cap_fields_pkg::*;
   localparam logic [11:0] ANP = 12'h15c;
   localparam logic [11:0] PNP = 12'h160;
   localparam logic [3:0]  AVER = 4'h2;
   localparam logic [3:0]  PVER = 4'h3;
   localparam logic [7:0]  ANF  = 8'h03;
   localparam logic [9:0]  SNP  = 10'h2a5;
   localparam logic [9:0]  NSNP = 10'h15a;
   logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   logic        rready = 0, awready, wready, bvalid, arready, rvalid;
   logic        ecrc_generate_enable, ecrc_check_enable, alt_routing_enable_cfg;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, rd;
   logic [3:0]  wstrb = 0;
   logic [1:0]  bresp, rresp, rs;
   logic [9:0]  max_snoop_latency, max_nosnoop_latency;
   logic [7:0]  rid_bus, rid_function;
   logic [4:0]  rid_device;
   logic        l_gen, l_chk, l_alt;
   logic [7:0]  l_bus, l_func;
   logic [4:0]  l_dev;
   int          err_count = 0;
   int          n_tests = 0;
   pcie_ext_capability_fields #(.ECRC_CHECK_CAPABLE(1'h1), .ALT_ROUTING_ENABLE(1'h1),
      .ALT_NEXT_PTR(ANP), .ALT_VERSION(AVER), .ALT_NEXT_FUNCTION(ANF), .PB_NEXT_PTR(PNP),
      .PB_VERSION(PVER), .PB_SYS_ALLOCATED(1'h1), .MAX_SNOOP_LATENCY(SNP),
      .MAX_NOSNOOP_LATENCY(NSNP)) dut_u (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
      .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .ecrc_generate_enable, .ecrc_check_enable, .alt_routing_enable_cfg, .max_snoop_latency,
      .max_nosnoop_latency, .rid_bus, .rid_device, .rid_function);
   // legacy id split and generate capable, fed by the same bus stimulus
   pcie_ext_capability_fields #(.ECRC_GENERATE_CAPABLE(1'h1)) legacy_u (
      .aclk, .aresetn, .awaddr, .awvalid, .awready(), .wdata, .wstrb, .wvalid, .wready(),
      .bresp(), .bvalid(), .bready, .araddr, .arvalid, .arready(), .rdata(), .rresp(),
      .rvalid(), .rready, .ecrc_generate_enable(l_gen), .ecrc_check_enable(l_chk),
      .alt_routing_enable_cfg(l_alt), .max_snoop_latency(), .max_nosnoop_latency(),
      .rid_bus(l_bus), .rid_device(l_dev), .rid_function(l_func));
   initial
   begin
      forever #10 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // handshakes judged at the falling edge, released after the taking rising edge
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic ta, tw, tb;
      tb = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!tb)
      begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         rs = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask : wr
   task automatic rd_reg(input logic [11:0] a);
      logic ta, tr;
      tr = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!tr)
      begin
         @(negedge aclk);
         ta = arvalid && arready;
         tr = rvalid;
         rd = rdata;
         rs = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask : rd_reg
   task automatic t_fields;
      rd_reg(12'h008);
      chk(rd, {ANP, 4'h2, 16'h0000});
      rd_reg(12'h010);
      chk(rd, {PNP, 4'h3, 16'h0000});
      rd_reg(12'h018);
      chk(rd, 32'h0001_0000);
      rd_reg(12'h00c);
      chk({24'h0, rd[15:8]}, 32'h3);
      rd_reg(12'h014);
      chk({31'h0, rd[0]}, 32'h1);
      rd_reg(12'h004);
      chk(rd, 32'h80);
      $display("fields done");
   endtask : t_fields
   task automatic t_writes;
      wr(12'h008, 32'h0, 4'hf);
      chk({30'h0, rs}, {30'h0, RESP_OKAY});
      rd_reg(12'h008);
      chk(rd, {ANP, 4'h2, 16'h0000});
      // generate enable must stay low: not generate capable
      wr(12'h004, 32'hffff_ffff, 4'hf);
      rd_reg(12'h004);
      chk(rd, 32'h180);
      chk({30'h0, ecrc_generate_enable, ecrc_check_enable}, 32'h1);
      chk({30'h0, l_gen, l_chk}, 32'h2);
      rd_reg(12'h01c);
      chk(rd, 32'h015a_02a5);
      wr(12'h01c, 32'hffff_0155, 4'h3);
      rd_reg(12'h01c);
      chk(rd, 32'h015a_0155);
      chk({6'h0, max_nosnoop_latency, 6'h0, max_snoop_latency}, 32'h015a_0155);
      $display("writes done");
   endtask : t_writes
   task automatic t_rid;
      wr(12'h020, 32'h0000_abcd, 4'hf);
      rd_reg(12'h024);
      chk(rd, 32'h00cd_00ab);
      chk({rid_bus, 3'h0, rid_device, rid_function, 7'h0, alt_routing_enable_cfg},
          32'hab00_cd01);
      chk({l_bus, 3'h0, l_dev, l_func, 7'h0, l_alt}, 32'hab19_0500);
      wr(12'h044, 32'h0, 4'hf);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      rd_reg(12'h040);
      chk({28'h0, rs, 2'h0}, {28'h0, RESP_SLVERR, 2'h0});
      $display("requester id done");
   endtask : t_rid
   // mid-run reset must bring back the configured latencies and clear enables
   task automatic t_reset;
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      chk({12'h0, max_nosnoop_latency, max_snoop_latency}, {12'h0, NSNP, SNP});
      chk({30'h0, ecrc_generate_enable, ecrc_check_enable}, 32'h0);
      $display("reset done");
   endtask : t_reset
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      t_fields;
      t_writes;
      t_rid;
      t_reset;
      print_verdict;
   end
   initial
   begin
      repeat (3000) @(posedge aclk);
      err_count++;
      print_verdict;
   end
endmodule : pcie_ext_capability_fields_bench
